/* inc/wbc_pkg.sv */
package wbc_pkg;

  // Device operating modes as seen by this register bank.
  typedef enum logic [1:0] {
    WBC_MODE_INIT,
    WBC_MODE_NORMAL,
    WBC_MODE_STOP,
    WBC_MODE_SLEEP
  } wbc_mode_e;

  // Register addresses.
  localparam logic [6:0] ADDR_SUPPLY = 7'h02;
  localparam logic [6:0] ADDR_WDOG = 7'h03;
  localparam logic [6:0] ADDR_BUS1 = 7'h04;
  localparam logic [6:0] ADDR_BUS2 = 7'h05;
  localparam logic [6:0] ADDR_IWAKE = 7'h06;
  localparam logic [6:0] ADDR_EWAKE = 7'h07;

  // Power-on and soft reset values.
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_WDOG = 8'h14;
  localparam logic [7:0] RST_BUS1 = 8'h20;
  localparam logic [7:0] RST_BUS2 = 8'h00;
  localparam logic [7:0] RST_IWAKE = 8'h00;
  localparam logic [7:0] RST_EWAKE = 8'h07;
  localparam logic [7:0] SR_KEEP_SUPPLY = 8'h88;

  // Implemented bits; all others are reserved and read as zero.
  localparam logic [7:0] IMPL_SUPPLY = 8'hFB;
  localparam logic [7:0] IMPL_WDOG = 8'hF7;
  localparam logic [7:0] IMPL_BUS1 = 8'hFB;
  localparam logic [7:0] IMPL_BUS2 = 8'h20;
  localparam logic [7:0] IMPL_IWAKE = 8'hC4;
  localparam logic [7:0] IMPL_EWAKE = 8'hA7;

  // Restart: kept bits and forced values.
  localparam logic [7:0] RS_KEEP_SUPPLY = 8'hD9;
  localparam logic [7:0] RS_KEEP_WDOG = 8'hB0;
  localparam logic [7:0] RS_SET_WDOG = 8'h04;
  localparam logic [7:0] RS_KEEP_BUS1 = 8'hFB;
  localparam logic [7:0] RS_KEEP_BUS2 = 8'h20;
  localparam logic [7:0] RS_KEEP_IWAKE = 8'hC0;
  localparam logic [7:0] RS_KEEP_EWAKE = 8'hA7;

  // Fail-safe entry: kept bits and forced wake values.
  localparam logic [7:0] FS_KEEP_BUS1 = 8'hE0;
  localparam logic [7:0] FS_SET_BUS1 = 8'h09;
  localparam logic [7:0] FS_KEEP_EWAKE = 8'hA0;
  localparam logic [7:0] FS_SET_EWAKE = 8'h07;

  // Field positions.
  localparam int SUP_VSEL = 7;
  localparam int SUP_FO = 5;
  localparam int SUP_LS = 3;
  localparam int WD_PAR = 7;
  localparam int WD_STOP = 6;
  localparam int WD_WSEL = 5;
  localparam int WD_BUSWK = 4;
  localparam int WD_PER_LSB = 0;
  localparam int B1_FLASH = 7;
  localparam int B1_LSM = 6;
  localparam int B1_TXD = 5;
  localparam int B1_LIN_LSB = 3;
  localparam int B1_CAN_LSB = 0;
  localparam int B2_PEAK = 5;
  localparam int EW_GLOBAL = 7;

  // Watchdog period codes in milliseconds.
  localparam logic [2:0] WD_PER_RSVD = 3'h7;
  localparam logic [10:0] WD_MS_0 = 11'd10;
  localparam logic [10:0] WD_MS_1 = 11'd20;
  localparam logic [10:0] WD_MS_2 = 11'd50;
  localparam logic [10:0] WD_MS_3 = 11'd100;
  localparam logic [10:0] WD_MS_4 = 11'd200;
  localparam logic [10:0] WD_MS_5 = 11'd500;
  localparam logic [10:0] WD_MS_6 = 11'd1000;

  // Serial frame layout, first bit on the wire is bit 0.
  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] DATA_START = 5'd8;
  localparam int FRM_WR = 7;

  function automatic logic [10:0] period_ms(input logic [2:0] code);
    unique case (code)
      3'h0: period_ms = WD_MS_0;
      3'h1: period_ms = WD_MS_1;
      3'h2: period_ms = WD_MS_2;
      3'h3: period_ms = WD_MS_3;
      3'h4: period_ms = WD_MS_4;
      3'h5: period_ms = WD_MS_5;
      3'h6: period_ms = WD_MS_6;
      3'h7: period_ms = WD_MS_6;
    endcase
  endfunction : period_ms

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

endpackage : wbc_pkg

/* hw/wbc_spi_slave.sv */
`timescale 1ns/100ps
module wbc_spi_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Register side
  input wire logic [7:0] rd_data,
  output logic [6:0] rd_addr,
  output logic frm_done,
  output logic frm_bad,
  output logic frm_wr,
  output logic [7:0] frm_data
);
  import wbc_pkg::*;

  typedef struct packed {
    logic cs_p;
    logic sclk_p;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic sdo;
    logic done;
    logic bad;
  } wbc_spi_s;

  wbc_spi_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.cs_p = chip_select_n;
    s_d.sclk_p = sclk;
    s_d.done = 1'b0;
    s_d.bad = 1'b0;
    if (s_q.cs_p && !chip_select_n) begin
      s_d.cnt = 5'd0;
      s_d.sh = 16'h0000;
      s_d.sdo = 1'b0;
    end else if (!s_q.cs_p && chip_select_n) begin
      // Only a frame of exactly sixteen clocks is acted on.
      s_d.done = (s_q.cnt == FRAME_BITS);
      s_d.bad = (s_q.cnt != FRAME_BITS);
    end else if (!chip_select_n) begin
      if (!s_q.sclk_p && sclk && s_q.cnt <= FRAME_BITS) begin
        if (s_q.cnt < FRAME_BITS) begin
          s_d.sh[s_q.cnt[3:0]] = sdi;
        end
        s_d.cnt = s_q.cnt + 5'd1;
      end else if (s_q.sclk_p && !sclk) begin
        // The old contents go out, so a write frame echoes the prior value.
        if (s_q.cnt >= DATA_START && s_q.cnt < FRAME_BITS) begin
          s_d.sdo = rd_data[s_q.cnt[2:0]];
        end else begin
          s_d.sdo = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '{cs_p: 1'b1, sclk_p: 1'b0, cnt: 5'd0, sh: 16'h0000, sdo: 1'b0,
               done: 1'b0, bad: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sdo = s_q.sdo;
  assign sdo_oe = !chip_select_n;
  assign rd_addr = s_q.sh[6:0];
  assign frm_wr = s_q.sh[FRM_WR];
  assign frm_data = s_q.sh[15:8];
  assign frm_done = s_q.done;
  assign frm_bad = s_q.bad;

endmodule : wbc_spi_slave

/* hw/wbc_int_route.sv */
`timescale 1ns/100ps
module wbc_int_route #(
  parameter int STATUS_W = 8,
  parameter int WAKE_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sources
  input wire logic global_all,
  input wire logic [STATUS_W-1:0] status_events,
  input wire logic [WAKE_W-1:0] wake_events,
  // Interrupt request
  output logic int_req
);
  typedef struct packed {
    logic irq;
  } wbc_irq_s;

  wbc_irq_s i_q, i_d;

  always_comb begin
    i_d = i_q;
    // Wake sources always count; other status only in global mode.
    i_d.irq = (|wake_events) || (global_all && (|status_events));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      i_q <= '{irq: 1'b0};
    end else begin
      i_q <= i_d;
    end
  end

  assign int_req = i_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_int_status_gate: assert property (!global_all && wake_events == '0 |=> !int_req)
    else $error("status raised interrupt outside global mode");

endmodule : wbc_int_route

/* hw/wbc_regs.sv */
`timescale 1ns/100ps
module wbc_regs #(
  parameter int STATUS_W = 8,
  parameter int WAKE_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Device events and state
  input wire wbc_pkg::wbc_mode_e companion_chip_mode,
  input wire logic soft_reset_req,
  input wire logic restart_entry,
  input wire logic failsafe_entry,
  input wire logic failure_fo_req,
  input wire logic [STATUS_W-1:0] status_events,
  input wire logic [WAKE_W-1:0] wake_events,
  // Supply and fault controls
  output logic fault_outputs,
  output logic aux_reg_voltage_select,
  output logic aux_reg_load_share,
  // Watchdog controls
  output logic wdog_stop_disable_lo,
  output logic wdog_window_select,
  output logic wdog_start_on_bus_wake,
  output logic [2:0] wdog_period_code,
  output logic [10:0] wdog_period_ms,
  output logic wdog_parity_ok,
  // Transceiver controls
  output logic lin_slope_off,
  output logic low_slope_select,
  output logic transmit_timeout_enable,
  output logic [1:0] lin_port_mode,
  output logic [1:0] can_port_mode,
  output logic main_reg_peak_threshold,
  // Status
  output logic spi_frame_error,
  output logic int_req
);
  import wbc_pkg::*;

  typedef struct packed {
    logic [7:0] supply;
    logic [7:0] wdog;
    logic [7:0] bus1;
    logic [7:0] bus2;
    logic [7:0] iwake;
    logic [7:0] ewake;
    logic fo;
    logic ferr;
  } wbc_regs_s;

  wbc_regs_s r_q, r_d;

  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic frm_done;
  logic frm_bad;
  logic frm_wr;
  logic [7:0] frm_data;
  logic [7:0] wd_new;

  wbc_spi_slave u_spi (
    .clk(clk),
    .resetn(resetn),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .frm_done(frm_done),
    .frm_bad(frm_bad),
    .frm_wr(frm_wr),
    .frm_data(frm_data)
  );

  // Reserved positions are masked on read as well as on write.
  always_comb begin
    unique case (rd_addr)
      ADDR_SUPPLY: rd_data = r_q.supply & IMPL_SUPPLY;
      ADDR_WDOG: rd_data = r_q.wdog & IMPL_WDOG;
      ADDR_BUS1: rd_data = r_q.bus1 & IMPL_BUS1;
      ADDR_BUS2: rd_data = r_q.bus2 & IMPL_BUS2;
      ADDR_IWAKE: rd_data = r_q.iwake & IMPL_IWAKE;
      ADDR_EWAKE: rd_data = r_q.ewake & IMPL_EWAKE;
      default: rd_data = 8'h00;
    endcase
  end

  // A reserved period code must not reach the watchdog timer.
  always_comb begin
    wd_new = frm_data;
    if (frm_data[2:0] == WD_PER_RSVD) begin
      wd_new[2:0] = r_q.wdog[2:0];
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.ferr = frm_bad;
    if (soft_reset_req) begin
      // Set aux bits survive a soft reset; everything else reloads.
      r_d.supply = (r_q.supply & SR_KEEP_SUPPLY) | RST_SUPPLY;
      r_d.wdog = RST_WDOG;
      r_d.bus1 = RST_BUS1;
      r_d.bus2 = RST_BUS2;
      r_d.iwake = RST_IWAKE;
      r_d.ewake = RST_EWAKE;
    end else if (failsafe_entry) begin
      // Wake paths are forced on so the device can still be woken.
      r_d.bus1 = merge(FS_SET_BUS1, r_q.bus1, FS_KEEP_BUS1);
      r_d.ewake = merge(FS_SET_EWAKE, r_q.ewake, FS_KEEP_EWAKE);
    end else if (restart_entry) begin
      r_d.supply = r_q.supply & RS_KEEP_SUPPLY;
      r_d.wdog = merge(RS_SET_WDOG, r_q.wdog, RS_KEEP_WDOG);
      r_d.bus1 = r_q.bus1 & RS_KEEP_BUS1;
      r_d.bus2 = r_q.bus2 & RS_KEEP_BUS2;
      r_d.iwake = r_q.iwake & RS_KEEP_IWAKE;
      r_d.ewake = r_q.ewake & RS_KEEP_EWAKE;
    end else if (frm_done && frm_wr) begin
      // Commit happens on the chip select rise, so options act at once.
      unique case (rd_addr)
        ADDR_SUPPLY: r_d.supply = frm_data & IMPL_SUPPLY;
        ADDR_WDOG: r_d.wdog = wd_new & IMPL_WDOG;
        ADDR_BUS1: r_d.bus1 = frm_data & IMPL_BUS1;
        ADDR_BUS2: begin
          // Outside init and normal mode the write is dropped; no frame error follows.
          if (companion_chip_mode == WBC_MODE_INIT || companion_chip_mode == WBC_MODE_NORMAL) begin
            r_d.bus2 = frm_data & IMPL_BUS2;
          end
        end
        ADDR_IWAKE: r_d.iwake = frm_data & IMPL_IWAKE;
        ADDR_EWAKE: r_d.ewake = frm_data & IMPL_EWAKE;
        default: r_d.ferr = 1'b0;
      endcase
    end
    // Software activation or a device failure drives the fault outputs.
    r_d.fo = r_d.supply[SUP_FO] | failure_fo_req;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_q <= '{supply: RST_SUPPLY, wdog: RST_WDOG, bus1: RST_BUS1, bus2: RST_BUS2,
               iwake: RST_IWAKE, ewake: RST_EWAKE, fo: 1'b0, ferr: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  wbc_int_route #(
    .STATUS_W(STATUS_W),
    .WAKE_W(WAKE_W)
  ) u_int (
    .clk(clk),
    .resetn(resetn),
    .global_all(r_q.ewake[EW_GLOBAL]),
    .status_events(status_events),
    .wake_events(wake_events),
    .int_req(int_req)
  );

  assign fault_outputs = r_q.fo;
  assign aux_reg_voltage_select = r_q.supply[SUP_VSEL];
  assign aux_reg_load_share = r_q.supply[SUP_LS];
  assign wdog_stop_disable_lo = r_q.wdog[WD_STOP];
  assign wdog_window_select = r_q.wdog[WD_WSEL];
  assign wdog_start_on_bus_wake = r_q.wdog[WD_BUSWK];
  assign wdog_period_code = r_q.wdog[WD_PER_LSB +: 3];
  assign wdog_period_ms = period_ms(r_q.wdog[WD_PER_LSB +: 3]);
  // The host owns the parity; the bank only reports whether it holds.
  assign wdog_parity_ok = ~^r_q.wdog;
  assign lin_slope_off = r_q.bus1[B1_FLASH];
  assign low_slope_select = r_q.bus1[B1_LSM];
  assign transmit_timeout_enable = r_q.bus1[B1_TXD];
  assign lin_port_mode = r_q.bus1[B1_LIN_LSB +: 2];
  assign can_port_mode = r_q.bus1[B1_CAN_LSB +: 2];
  assign main_reg_peak_threshold = r_q.bus2[B2_PEAK];
  assign spi_frame_error = r_q.ferr;

  logic evt_none;
  logic wr_cmt;
  assign evt_none = !soft_reset_req && !failsafe_entry && !restart_entry;
  assign wr_cmt = evt_none && frm_done && frm_wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_restart_fo_off: assert property (
      restart_entry && !soft_reset_req && !failsafe_entry && !failure_fo_req
      |=> !fault_outputs && !r_q.supply[SUP_FO])
    else $error("fault outputs still on after restart");
  a_soft_keep_aux: assert property (
      soft_reset_req |=> r_q.supply == ($past(r_q.supply) & SR_KEEP_SUPPLY))
    else $error("soft reset did not keep aux bits");
  a_wdog_restart_val: assert property (
      restart_entry && !soft_reset_req && !failsafe_entry
      |=> r_q.wdog == (($past(r_q.wdog) & RS_KEEP_WDOG) | RS_SET_WDOG))
    else $error("watchdog setup restart value wrong");
  a_bus1_soft_val: assert property (
      soft_reset_req |=> r_q.bus1 == RST_BUS1 && r_q.iwake == RST_IWAKE
      && r_q.bus2 == RST_BUS2)
    else $error("bus setup soft reset value wrong");
  a_reserved_zero: assert property (
      (r_q.wdog & ~IMPL_WDOG) == 8'h00 && (r_q.bus1 & ~IMPL_BUS1) == 8'h00
      && (r_q.bus2 & ~IMPL_BUS2) == 8'h00)
    else $error("reserved bit became set");
  a_period_hold: assert property (
      wr_cmt && rd_addr == ADDR_WDOG && frm_data[2:0] == WD_PER_RSVD
      |=> $stable(wdog_period_code))
    else $error("reserved period code was accepted");
  a_failsafe_wake: assert property (
      failsafe_entry && !soft_reset_req |=> r_q.bus1[4:0] == FS_SET_BUS1[4:0]
      && r_q.ewake[6:0] == {1'b0, $past(r_q.ewake[5]), 5'h07})
    else $error("fail-safe wake values not forced");
  a_peak_stop_drop: assert property (
      wr_cmt && rd_addr == ADDR_BUS2 && companion_chip_mode == WBC_MODE_STOP
      |=> $stable(main_reg_peak_threshold) && !spi_frame_error)
    else $error("peak threshold changed in stop mode");
  a_lin_opt_apply: assert property (
      wr_cmt && rd_addr == ADDR_BUS1 |=>
      {lin_slope_off, low_slope_select, transmit_timeout_enable} == $past(frm_data[7:5]))
    else $error("LIN options not applied at frame end");

  c_restart: cover property (restart_entry && r_q.supply[SUP_FO]);
  c_failsafe: cover property (failsafe_entry ##1 lin_port_mode == 2'h1);
  c_wdog_write: cover property (wr_cmt && rd_addr == ADDR_WDOG);
  c_stop_drop: cover property (wr_cmt && rd_addr == ADDR_BUS2
      && companion_chip_mode == WBC_MODE_STOP);

endmodule : wbc_regs

/* dv/wbc_host_model.sv */
`timescale 1ns/100ps
module wbc_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo
);
  int half_clk = 3;

  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end

  // The host keeps the watchdog byte at even parity through bit 7.
  function automatic logic [7:0] with_checksum(input logic [7:0] d);
    return {^d[6:0], d[6:0]};
  endfunction : with_checksum

  // Sends nbits of word, first bit is bit 0; returns what sdo showed during bits 8 to 15.
  task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
    rdata = 8'h00;
    @(negedge clk);
    chip_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = word[i];
      repeat (half_clk) @(negedge clk);
      if (i >= 8) rdata[i-8] = sdo;
      sclk = 1'b1;
      repeat (half_clk) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (half_clk) @(negedge clk);
    chip_select_n = 1'b1;
    // A released line must not look like it still holds the last bit.
    sdi = ~sdi;
    repeat (half_clk + 1) @(negedge clk);
  endtask : frame
endmodule : wbc_host_model

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import wbc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sclk, chip_select_n, sdi, sdo, sdo_oe;
  wbc_mode_e companion_chip_mode = WBC_MODE_NORMAL;
  logic soft_reset_req = 1'b0, restart_entry = 1'b0, failsafe_entry = 1'b0;
  logic failure_fo_req = 1'b0;
  logic [7:0] status_events = 8'h00, wake_events = 8'h00;
  logic fault_outputs, aux_reg_voltage_select, aux_reg_load_share, wdog_stop_disable_lo;
  logic wdog_window_select, wdog_start_on_bus_wake, wdog_parity_ok, lin_slope_off;
  logic low_slope_select, transmit_timeout_enable, main_reg_peak_threshold;
  logic spi_frame_error, int_req;
  logic [2:0] wdog_period_code;
  logic [10:0] wdog_period_ms;
  logic [1:0] lin_port_mode, can_port_mode;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 27284;
  int err_pulses = 0;
  int oe_bad = 0;
  int e0;
  logic [7:0] r;
  logic [7:0] shadow [0:7];
  logic [10:0] ms_tab [0:7] = '{11'h00a, 11'h014, 11'h032, 11'h064, 11'h0c8, 11'h1f4,
                                11'h3e8, 11'h3e8};

  always #2 clk = ~clk;
  always @(posedge clk) if (spi_frame_error === 1'b1) err_pulses++;
  // Chip select only moves on falling edges, so the enable is settled here.
  always @(posedge clk) if (sdo_oe !== !chip_select_n) oe_bad++;

  wbc_host_model host (.clk(clk), .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
    .sdo(sdo));

  wbc_regs uut (.clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .companion_chip_mode(companion_chip_mode),
    .soft_reset_req(soft_reset_req), .restart_entry(restart_entry),
    .failsafe_entry(failsafe_entry), .failure_fo_req(failure_fo_req),
    .status_events(status_events), .wake_events(wake_events), .fault_outputs(fault_outputs),
    .aux_reg_voltage_select(aux_reg_voltage_select), .aux_reg_load_share(aux_reg_load_share),
    .wdog_stop_disable_lo(wdog_stop_disable_lo), .wdog_window_select(wdog_window_select),
    .wdog_start_on_bus_wake(wdog_start_on_bus_wake), .wdog_period_code(wdog_period_code),
    .wdog_period_ms(wdog_period_ms), .wdog_parity_ok(wdog_parity_ok),
    .lin_slope_off(lin_slope_off), .low_slope_select(low_slope_select),
    .transmit_timeout_enable(transmit_timeout_enable), .lin_port_mode(lin_port_mode),
    .can_port_mode(can_port_mode), .main_reg_peak_threshold(main_reg_peak_threshold),
    .spi_frame_error(spi_frame_error), .int_req(int_req));

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [7:0] sh(input logic [6:0] a);
    return (a < 8) ? shadow[a[2:0]] : 8'h00;
  endfunction : sh

  // Stored value after a write of d over old.
  function automatic logic [7:0] next_val(input logic [6:0] a, input logic [7:0] d,
                                          input logic [7:0] old);
    logic [7:0] v;
    case (a)
      ADDR_SUPPLY: v = d & IMPL_SUPPLY;
      ADDR_WDOG: begin
        v = d & IMPL_WDOG;
        if (d[2:0] == WD_PER_RSVD) v[2:0] = old[2:0];
      end
      ADDR_BUS1: v = d & IMPL_BUS1;
      ADDR_BUS2: begin
        v = old;
        if (companion_chip_mode == WBC_MODE_INIT || companion_chip_mode == WBC_MODE_NORMAL) begin
          v = d & IMPL_BUS2;
        end
      end
      ADDR_IWAKE: v = d & IMPL_IWAKE;
      ADDR_EWAKE: v = d & IMPL_EWAKE;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : next_val

  task automatic reset_model(input logic [7:0] sup);
    shadow = '{8'h00, 8'h00, sup, RST_WDOG, RST_BUS1, RST_BUS2, RST_IWAKE, RST_EWAKE};
  endtask : reset_model

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    x = (a == ADDR_WDOG) ? host.with_checksum(d) : d;
    host.frame({x, 1'b1, a}, 16, r);
    check($sformatf("echo %h", a), r, sh(a));
    if (a < 8) shadow[a[2:0]] = next_val(a, x, shadow[a[2:0]]);
  endtask : wr

  task automatic rd(input logic [6:0] a);
    host.frame({8'h00, 1'b0, a}, 16, r);
    check($sformatf("read %h", a), r, sh(a));
  endtask : rd

  task automatic check_ports;
    logic [7:0] w;
    logic [7:0] b;
    w = shadow[3];
    b = shadow[4];
    check("fault_outputs", fault_outputs, shadow[2][5] | failure_fo_req);
    check("aux_v", aux_reg_voltage_select, shadow[2][7]);
    check("aux_ls", aux_reg_load_share, shadow[2][3]);
    check("wd_stop", wdog_stop_disable_lo, w[6]);
    check("wdog_window_select", wdog_window_select, w[5]);
    check("wd_bus", wdog_start_on_bus_wake, w[4]);
    check("wd_code", wdog_period_code, w[2:0]);
    check("wd_ms", wdog_period_ms, ms_tab[w[2:0]]);
    check("wd_par", wdog_parity_ok, ~^w);
    check("flash", lin_slope_off, b[7]);
    check("lsm", low_slope_select, b[6]);
    check("txd_to", transmit_timeout_enable, b[5]);
    check("lin", lin_port_mode, b[4:3]);
    check("can", can_port_mode, b[1:0]);
    check("peak", main_reg_peak_threshold, shadow[5][5]);
    check("int", int_req, |wake_events | (shadow[7][7] & |status_events));
  endtask : check_ports

  task automatic check_all;
    for (int a = 0; a < 8; a++) rd(7'(a));
    check_ports;
  endtask : check_all

  // Events: 0 soft reset, 1 fail-safe entry, 2 restart entry.
  task automatic fire(input int k);
    @(negedge clk);
    case (k)
      0: begin
        soft_reset_req = 1'b1;
        reset_model(RST_SUPPLY | (shadow[2] & SR_KEEP_SUPPLY));
      end
      1: begin
        failsafe_entry = 1'b1;
        shadow[4] = (shadow[4] & FS_KEEP_BUS1) | FS_SET_BUS1;
        shadow[7] = (shadow[7] & FS_KEEP_EWAKE) | FS_SET_EWAKE;
      end
      default: begin
        restart_entry = 1'b1;
        shadow[2] &= RS_KEEP_SUPPLY;
        shadow[3] = (shadow[3] & RS_KEEP_WDOG) | RS_SET_WDOG;
        shadow[4] &= RS_KEEP_BUS1;
        shadow[5] &= RS_KEEP_BUS2;
        shadow[6] &= RS_KEEP_IWAKE;
        shadow[7] &= RS_KEEP_EWAKE;
      end
    endcase
    @(negedge clk);
    {soft_reset_req, failsafe_entry, restart_entry} = 3'h0;
    @(negedge clk);
  endtask : fire

  // A hang counts against the run.
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    close_out;
  end

  initial begin
    reset_model(RST_SUPPLY);
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    check_all;
    wr(7'h55, 8'hff);
    rd(7'h55);
    wr(ADDR_WDOG, 8'h37);
    check_all;
    e0 = err_pulses;
    host.frame({8'hff, 1'b1, ADDR_BUS1}, 15, r);
    check("short frame", err_pulses - e0, 1);
    rd(ADDR_BUS1);
    companion_chip_mode = WBC_MODE_STOP;
    e0 = err_pulses;
    wr(ADDR_BUS2, 8'hff);
    check("stop write", err_pulses - e0, 0);
    rd(ADDR_BUS2);
    companion_chip_mode = WBC_MODE_NORMAL;
    wr(ADDR_SUPPLY, 8'hac);
    check_all;
    fire(2);
    check_all;
    wr(ADDR_SUPPLY, 8'h88);
    wr(ADDR_WDOG, 8'h65);
    fire(0);
    check_all;
    wr(ADDR_BUS1, 8'hff);
    wr(ADDR_EWAKE, 8'hff);
    fire(1);
    check_all;
    failure_fo_req = 1'b1;
    repeat (3) @(negedge clk);
    check_ports;
    failure_fo_req = 1'b0;
    for (int n = 0; n < 60; n++) begin
      @(negedge clk);
      companion_chip_mode = wbc_mode_e'(2'($random(seed)));
      status_events = 8'($random(seed));
      wake_events = 8'($random(seed) & $random(seed) & $random(seed));
      host.half_clk = 3 + 2 * ($random(seed) & 1);
      wr(7'($random(seed) & 7), 8'($random(seed)));
      rd(7'($random(seed) & 7));
      check_ports;
    end
    check("sdo_oe", oe_bad, 0);
    close_out;
  end
endmodule : testbench
